/* File: src/dlp_pkg.sv */
// Shared constants and types for the dual supply-section control block.
package dlp_pkg;

  // ****************************************
  // Bus address and register layout
  // ****************************************
  localparam logic [4:0] ADDR_FIXED = 5'h02;
  localparam logic [7:0] SREG_RESET = 8'h00;
  localparam int ADDR_DIR_BIT = 0;
  localparam int BITS_PER_BYTE = 8;

  // Write field positions.
  localparam int WR_LIMIT_MODE = 7;
  localparam int WR_TONE_OUT_EN = 6;
  localparam int WR_TONE_EN = 5;
  localparam int WR_DROP_COMP = 4;
  localparam int WR_VOLT_SEL = 3;
  localparam int WR_ENABLE = 2;
  localparam int WR_ITHR = 1;
  localparam int WR_AUX = 0;

  // Regulator level codes.
  localparam logic [2:0] LVL_OFF = 3'h0;
  localparam logic [2:0] LVL_BASE = 3'h1;
  localparam logic [2:0] LVL_BOOST = 3'h5;

  // ****************************************
  // Types
  // ****************************************
  typedef enum logic [2:0] {
    PH_IDLE, PH_ADDR, PH_AACK, PH_WDATA, PH_WACK, PH_RDATA, PH_RACK
  } dlp_phase_t;

  typedef struct packed {
    logic thermal_fault;
    logic overload;
    logic current_presence;
    logic voltage_monitor;
    logic tone_monitor;
  } dlp_diag_t;

  typedef struct packed {
    logic power_enable;
    logic [2:0] level_code;
    logic limit_mode_sel;
    logic current_threshold_sel;
    logic tone_out_enable;
    logic tone_active;
  } dlp_sec_out_t;

  typedef struct packed {
    logic uvlo;
    logic scl;
    logic sda;
    logic tog;
    logic [1:0][1:0] strap;
    dlp_diag_t [1:0] diag;
    logic [1:0] gate;
    logic [1:0] det;
  } dlp_pins_t;

  typedef struct packed {
    logic tog;
    logic val;
  } dlp_link_state_t;

endpackage : dlp_pkg

/* File: src/dlp_ctrl.sv */
// Dual supply-section controller with a two-wire serial slave interface.
`timescale 1ns/1ps
`default_nettype none

// ****************************************
// Link-clock bit capture
// ****************************************
module dlp_link
  import dlp_pkg::*;
(
  // Serial link
  input wire logic scl,
  input wire logic sda_in,
  // Captured bit toward the system clock
  output logic bit_tog,
  output logic bit_val
);
  // The link clock stands still outside frames, so no reset edge can be
  // relied on; the toggle is compared against its own history instead.
  dlp_link_state_t q = '0;
  dlp_link_state_t next_q;

  always_comb begin
    next_q = q;
    next_q.tog = ~q.tog;
    next_q.val = sda_in;
  end

  always_ff @(posedge scl) begin
    q <= next_q;
  end

  assign bit_tog = q.tog;
  assign bit_val = q.val;
endmodule : dlp_link

// Notes on behaviour
// R01: Address byte bit zero gives direction: one reads, zero writes.
// R02: Address is fixed 00010 plus two strap bits chosen per section.
// R03: Transfer is start, address with ack, data byte with ack, stop.
// R04: Each section has one 8-bit register, all zero after power-on.
// R05: A write stores the data byte into the addressed section register.
// R06: Write bits high to low: limit, tone out, tone, drop, volt, en, ithr, aux.
// R07: Read bits: presence, voltage, tone, drop, volt, en, thermal, overload.
// R08: Tone enable low with tone output on gates the tone by the gate pin.
// R09: Tone enable and tone output both high keep the tone running.
// R10: Tone output enable switches the tone generator; main supply stays on.
// R11: Limit mode zero selects pulsed limiting, one selects static limiting.
// R12: Threshold select zero picks the low, one the high current threshold.
// R13: In a read the device shifts a byte out, most significant bit first.
// R14: Master ack after a read byte sends another; no ack ends the read.
// R15: Read-back drop, voltage and enable bits equal the last written values.
// R16: Diagnostic flags read one while their fault is present, else zero.
// R17: Thermal fault sets its flag and disables the power blocks meanwhile.
// R18: Undervoltage lockout ignores the bus and holds both registers at zero.
// R19: The host may skip checking acks, waiting one clock instead.
// R20: The host raises tone output enable only while sending a tone.
// R21: Tone data passes on a gate input and a detected-tone output.
// R22: The device pulls data low on the ninth clock after each byte; the code acks only matched address bytes and write data bytes.
// R23: Enabled section drives a level code; aux boost forces the top level.
module dlp_ctrl
  import dlp_pkg::*;
(
  // System clock and reset
  input wire logic clock,
  input wire logic rst_n,
  // Serial bus
  input wire logic scl,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe,
  // Supply monitor and address straps
  input wire logic undervoltage_lockout,
  input wire logic [1:0] addr_strap_a,
  input wire logic [1:0] addr_strap_b,
  // Section diagnostics and tone pins, index 0 is section A
  input wire dlp_diag_t [1:0] diag_in,
  input wire logic [1:0] tone_gate_in,
  input wire logic [1:0] tone_detector_input,
  output logic [1:0] tone_detect_out,
  // Section power controls
  output dlp_sec_out_t [1:0] sec_out
);

  typedef struct packed {
    dlp_pins_t s1;
    dlp_pins_t s2;
    logic scl_d;
    logic sda_d;
    logic tog_d;
    dlp_phase_t phase;
    logic [3:0] cnt;
    logic [7:0] shreg;
    logic [7:0] tx;
    logic sec;
    logic [1:0][1:0] strap;
    logic [1:0][7:0] sreg;
    dlp_sec_out_t [1:0] out;
    logic [1:0] det;
    logic drive;
  } dlp_state_t;

  dlp_state_t q;
  dlp_state_t next_q;
  dlp_pins_t pins_now;
  logic link_tog;
  logic link_val;

  // ****************************************
  // Helpers
  // ****************************************
  function automatic logic addr_hit(input logic [7:0] a, input logic [1:0] strap);
    // R02 address compare
    addr_hit = (a[7:3] == ADDR_FIXED) && (a[2:1] == strap);
  endfunction : addr_hit

  function automatic logic [7:0] status_byte(input logic [7:0] c, input dlp_diag_t d);
    // R07 read layout
    // R15 control mirror
    // R16 fault flags
    status_byte = {d.current_presence, d.voltage_monitor, d.tone_monitor,
                   c[WR_DROP_COMP], c[WR_VOLT_SEL], c[WR_ENABLE],
                   d.thermal_fault, d.overload};
  endfunction : status_byte

  dlp_link u_link (
    .scl(scl),
    .sda_in(sda_in),
    .bit_tog(link_tog),
    .bit_val(link_val)
  );

  always_comb begin
    pins_now = '0;
    pins_now.uvlo = undervoltage_lockout;
    pins_now.scl = scl;
    pins_now.sda = sda_in;
    pins_now.tog = link_tog;
    pins_now.strap[0] = addr_strap_a;
    pins_now.strap[1] = addr_strap_b;
    pins_now.diag = diag_in;
    pins_now.gate = tone_gate_in;
    pins_now.det = tone_detector_input;
  end

  // ****************************************
  // Next state
  // ****************************************
  always_comb begin
    logic start_ev;
    logic stop_ev;
    logic fall_ev;
    logic bit_ev;
    logic [7:0] byte_in;
    logic [7:0] c;
    logic en_eff;
    start_ev = 1'b0;
    stop_ev = 1'b0;
    fall_ev = 1'b0;
    bit_ev = 1'b0;
    byte_in = 8'h00;
    c = 8'h00;
    en_eff = 1'b0;

    next_q = q;
    next_q.s1 = pins_now;
    next_q.s2 = q.s1;
    next_q.scl_d = q.s2.scl;
    next_q.sda_d = q.s2.sda;
    next_q.tog_d = q.s2.tog;

    start_ev = q.s2.scl && q.scl_d && q.sda_d && !q.s2.sda;
    stop_ev = q.s2.scl && q.scl_d && !q.sda_d && q.s2.sda;
    fall_ev = q.scl_d && !q.s2.scl;
    bit_ev = q.s2.tog ^ q.tog_d;
    byte_in = {q.shreg[6:0], link_val};

    // R03 framing
    if (start_ev) begin
      next_q.phase = PH_ADDR;
      next_q.cnt = 4'h0;
    end else if (stop_ev) begin
      next_q.phase = PH_IDLE;
    end else if (bit_ev) begin
      unique case (q.phase)
        PH_IDLE: begin
        end
        PH_ADDR: begin
          next_q.shreg = byte_in;
          next_q.cnt = q.cnt + 4'h1;
          if (q.cnt == 4'(BITS_PER_BYTE - 1)) begin
            next_q.cnt = 4'h0;
            next_q.phase = PH_IDLE;
            if (addr_hit(byte_in, q.strap[0])) begin
              next_q.phase = PH_AACK;
              next_q.sec = 1'b0;
            end else if (addr_hit(byte_in, q.strap[1])) begin
              next_q.phase = PH_AACK;
              next_q.sec = 1'b1;
            end
          end
        end
        PH_AACK: begin
          next_q.cnt = 4'h0;
          // R01 direction bit
          if (q.shreg[ADDR_DIR_BIT]) begin
            next_q.phase = PH_RDATA;
            next_q.tx = status_byte(q.sreg[q.sec], q.s2.diag[q.sec]);
          end else begin
            next_q.phase = PH_WDATA;
          end
        end
        PH_WDATA: begin
          next_q.shreg = byte_in;
          next_q.cnt = q.cnt + 4'h1;
          if (q.cnt == 4'(BITS_PER_BYTE - 1)) begin
            // R05 store written byte
            next_q.sreg[q.sec] = byte_in;
            next_q.phase = PH_WACK;
            next_q.cnt = 4'h0;
          end
        end
        PH_WACK: begin
          next_q.phase = PH_IDLE;
        end
        PH_RDATA: begin
          next_q.cnt = q.cnt + 4'h1;
          if (q.cnt == 4'(BITS_PER_BYTE - 1)) begin
            next_q.phase = PH_RACK;
            next_q.cnt = 4'h0;
          end
        end
        PH_RACK: begin
          // R14 master ack continues
          if (!link_val) begin
            next_q.phase = PH_RDATA;
            next_q.cnt = 4'h0;
            next_q.tx = status_byte(q.sreg[q.sec], q.s2.diag[q.sec]);
          end else begin
            next_q.phase = PH_IDLE;
          end
        end
      endcase
    end

    // Apart from clearing on start, stop, lockout and reset, the data line only changes while the clock is low.
    if (start_ev || stop_ev) begin
      next_q.drive = 1'b0;
    end else if (fall_ev) begin
      unique case (q.phase)
        // R22 acknowledge pull-down
        PH_AACK, PH_WACK: next_q.drive = 1'b1;
        // R13 msb first
        PH_RDATA: next_q.drive = !q.tx[3'(BITS_PER_BYTE - 1) - q.cnt[2:0]];
        default: next_q.drive = 1'b0;
      endcase
    end

    // R18 lockout holds the interface
    if (q.s2.uvlo) begin
      next_q.phase = PH_IDLE;
      next_q.drive = 1'b0;
      next_q.sreg = {SREG_RESET, SREG_RESET};
    end

    // R04 power-on clear
    if (!rst_n) begin
      next_q.phase = PH_IDLE;
      next_q.cnt = 4'h0;
      next_q.drive = 1'b0;
      next_q.sreg = {SREG_RESET, SREG_RESET};
      next_q.strap = q.s2.strap;
      next_q.tog_d = q.s2.tog;
    end

    for (int i = 0; i < 2; i++) begin
      c = next_q.sreg[i];
      // R17 thermal shutdown
      en_eff = c[WR_ENABLE] && !q.s2.diag[i].thermal_fault && !q.s2.uvlo;
      next_q.out[i].power_enable = en_eff;
      // R23 level code
      if (!en_eff) begin
        next_q.out[i].level_code = LVL_OFF;
      end else if (c[WR_AUX]) begin
        next_q.out[i].level_code = LVL_BOOST;
      end else begin
        next_q.out[i].level_code = LVL_BASE + {1'b0, c[WR_VOLT_SEL], c[WR_DROP_COMP]};
      end
      // R06 write layout
      // R11 limit mode
      next_q.out[i].limit_mode_sel = c[WR_LIMIT_MODE];
      // R12 threshold select
      next_q.out[i].current_threshold_sel = c[WR_ITHR];
      // R10 tone generator switch
      next_q.out[i].tone_out_enable = en_eff && c[WR_TONE_OUT_EN];
      // R08 gated tone
      // R09 continuous tone
      next_q.out[i].tone_active = en_eff && c[WR_TONE_OUT_EN]
                                  && (c[WR_TONE_EN] || q.s2.gate[i]);
      // R21 detected tone
      next_q.det[i] = q.s2.det[i];
    end
  end

  always_ff @(posedge clock) begin
    q <= next_q;
  end

  // ****************************************
  // Outputs
  // ****************************************
  assign sda_out = 1'b0;
  assign sda_oe = q.drive;
  assign sec_out = q.out;
  assign tone_detect_out = q.det;

endmodule : dlp_ctrl
`default_nettype wire

/* File: verif/dlp_ctrl_monitor.sv */
// Concurrent port checks for the supply-section controller.
`timescale 1ns/1ps
`default_nettype none
module dlp_ctrl_monitor
  import dlp_pkg::*;
(
  // Clock and reset
  input wire logic clock,
  input wire logic rst_n,
  // Bus and pins
  input wire logic scl,
  input wire logic sda_out,
  input wire logic sda_oe,
  input wire logic undervoltage_lockout,
  input wire dlp_diag_t [1:0] diag_in,
  input wire logic [1:0] tone_gate_in,
  input wire logic [1:0] tone_detector_input,
  input wire logic [1:0] tone_detect_out,
  input wire dlp_sec_out_t [1:0] sec_out
);
  default clocking @(posedge clock); endclocking
  default disable iff (!rst_n);
  sequence s_lock; undervoltage_lockout [*6]; endsequence
  sequence s_hot; diag_in[0].thermal_fault [*6]; endsequence
  sequence s_gated; (tone_gate_in[0] && sec_out[0].tone_out_enable) [*6]; endsequence
  property p_lock_quiet; s_lock |-> !sda_oe; endproperty
  a_lock_quiet: assert property (p_lock_quiet) else $error("ack in lockout");
  property p_lock_zero; s_lock |-> sec_out == '0; endproperty
  a_lock_zero: assert property (p_lock_zero) else $error("outputs set in lockout");
  property p_hot_off; s_hot |-> !sec_out[0].power_enable; endproperty
  a_hot_off: assert property (p_hot_off) else $error("power on while hot");
  property p_off_quiet; !sec_out[0].power_enable |-> !sec_out[0].tone_out_enable; endproperty
  a_off_quiet: assert property (p_off_quiet) else $error("tone out while off");
  property p_tone_out; sec_out[0].tone_active |-> sec_out[0].tone_out_enable; endproperty
  a_tone_out: assert property (p_tone_out) else $error("tone without output");
  property p_gate; s_gated |-> sec_out[0].tone_active; endproperty
  a_gate: assert property (p_gate) else $error("gated tone missing");
  property p_det;
    $stable(tone_detector_input) [*5] |-> tone_detect_out == tone_detector_input;
  endproperty
  a_det: assert property (p_det) else $error("detect out stale");
  property p_oe_edge;
    disable iff (!rst_n || undervoltage_lockout) $changed(sda_oe) |-> !scl && !$past(scl, 2);
  endproperty
  a_oe_edge: assert property (p_oe_edge) else $error("data moved with clock high");
  property p_oe_low; sda_oe |-> !sda_out; endproperty
  a_oe_low: assert property (p_oe_low) else $error("data driven high");
endmodule : dlp_ctrl_monitor
bind dlp_ctrl dlp_ctrl_monitor dlp_ctrl_monitor_i (.clock, .rst_n, .scl, .sda_out, .sda_oe,
  .undervoltage_lockout, .diag_in, .tone_gate_in, .tone_detector_input, .tone_detect_out,
  .sec_out);
`default_nettype wire

/* File: verif/dlp_host_model.sv */
// Two-wire bus master model standing in for the host controller.
`timescale 1ns/1ps
`default_nettype none
module dlp_host_model (
  // Bus lines, both idle high
  output logic scl,
  output logic sda_m,
  input wire logic sda
);
  initial begin
    scl = 1'b1;
    sda_m = 1'b1;
  end
  task automatic start();
    sda_m = 1'b0;
    #62.5 scl = 1'b0;
  endtask : start
  task automatic stop();
    #31.25 sda_m = 1'b0;
    #31.25 scl = 1'b1;
    #62.5 sda_m = 1'b1;
    #62.5;
  endtask : stop
  task automatic bits9(input logic [8:0] d, output logic [8:0] q);
    for (int i = 8; i >= 0; i--) begin
      #31.25 sda_m = d[i];
      #31.25 scl = 1'b1;
      #31.25 q[i] = sda;
      #31.25 scl = 1'b0;
    end
  endtask : bits9
endmodule : dlp_host_model
`default_nettype wire

/* File: verif/dlp_ctrl_bench.sv */
// Self-checking bench for the dual supply-section controller.
`timescale 1ns/1ps
`default_nettype none
module dlp_ctrl_bench;
  import dlp_pkg::*;
  localparam logic [6:0] AD_A = {ADDR_FIXED, 2'b00};
  localparam logic [6:0] AD_B = {ADDR_FIXED, 2'b01};
  logic clock = 1'b0;
  logic rst_n = 1'b0;
  logic uvlo = 1'b0;
  logic scl, sda_m, sda_out, sda_oe;
  dlp_diag_t [1:0] diag = '0;
  logic [1:0] gate = '0;
  logic [1:0] det = '0;
  logic [1:0] tdo, ak;
  dlp_sec_out_t [1:0] so;
  logic [2:0][7:0] rb;
  int bad_count = 0;
  int checks = 0;
  wire sda = sda_m & ~(sda_oe & ~sda_out);
  always #2.5 clock = ~clock;
  dlp_host_model dlp_host_model_i (.scl, .sda_m, .sda);
  dlp_ctrl dlp_ctrl_i (.clock, .rst_n, .scl, .sda_in(sda), .sda_out, .sda_oe,
    .undervoltage_lockout(uvlo), .addr_strap_a(2'b00), .addr_strap_b(2'b01),
    .diag_in(diag), .tone_gate_in(gate), .tone_detector_input(det),
    .tone_detect_out(tdo), .sec_out(so));
  task automatic chk(input string n, input logic [7:0] e, input logic [7:0] g);
    checks++;
    if (g !== e) begin
      bad_count++;
      $display("[ERR] %s expected %h seen %h", n, e, g);
    end
  endtask : chk
  task automatic cyc(input int n);
    repeat (n) @(posedge clock);
    #1;
  endtask : cyc
  task automatic bus_wr(input logic [6:0] a, input logic [7:0] d);
    logic [8:0] q1, q2;
    dlp_host_model_i.start();
    dlp_host_model_i.bits9({a, 2'b01}, q1);
    dlp_host_model_i.bits9({d, 1'b1}, q2);
    dlp_host_model_i.stop();
    ak = {q1[0], q2[0]};
  endtask : bus_wr
  // The third byte follows a master nack, so the device must stay silent.
  task automatic bus_rd(input logic [6:0] a);
    logic [8:0] q;
    dlp_host_model_i.start();
    dlp_host_model_i.bits9({a, 2'b11}, q);
    ak = {1'b0, q[0]};
    for (int i = 2; i >= 0; i--) begin
      dlp_host_model_i.bits9({8'hFF, i != 2}, q);
      rb[i] = q[8:1];
    end
    dlp_host_model_i.stop();
  endtask : bus_rd
  task automatic t_write_a();
    bus_wr(AD_A, 8'hEE);
    chk("wr_ack", 8'h00, 8'(ak));
    cyc(2);
    chk("sec_a", 8'hBF, so[0]);
    chk("sec_b", 8'h00, so[1]);
    for (int i = 0; i < 4; i++) begin
      bus_wr(AD_A, {3'b000, i[0], i[1], 3'b100});
      cyc(2);
      chk("level", {1'b1, 3'(i + 1), 4'h0}, so[0]);
    end
    bus_wr(AD_A, 8'h15);
    cyc(2);
    chk("boost", 8'hD0, so[0]);
  endtask : t_write_a
  task automatic t_read();
    bus_wr(AD_A, 8'hEE);
    diag[0] = 5'h0D;
    cyc(8);
    bus_rd(AD_A);
    chk("rd_ack", 8'h00, 8'(ak));
    chk("rd0", 8'hAD, rb[2]);
    chk("rd1", 8'hAD, rb[1]);
    chk("rd_end", 8'hFF, rb[0]);
  endtask : t_read
  task automatic t_thermal();
    diag[0].thermal_fault = 1'b1;
    cyc(8);
    chk("hot", 8'h00, 8'(so[0].power_enable));
    bus_rd(AD_A);
    chk("rd_hot", 8'hAF, rb[2]);
    diag[0] = '0;
    cyc(8);
    chk("cool", 8'h01, 8'(so[0].power_enable));
  endtask : t_thermal
  task automatic t_sec_b();
    bus_wr({ADDR_FIXED, 2'b10}, 8'h04);
    chk("miss_ack", 8'h03, 8'(ak));
    diag[1] = 5'h02;
    bus_wr(AD_B, 8'h0C);
    cyc(8);
    chk("sec_b", 8'hB0, so[1]);
    bus_rd(AD_B);
    chk("rd_b", 8'h4C, rb[2]);
  endtask : t_sec_b
  task automatic t_gate();
    bus_wr(AD_A, 8'h44);
    for (int g = 0; g < 2; g++) begin
      gate[0] = g[0];
      cyc(6);
      chk("gate", 8'h92 | 8'(g), so[0]);
    end
    for (int d = 1; d < 3; d++) begin
      det = 2'(d);
      cyc(5);
      chk("det", 8'(d), 8'(tdo));
    end
  endtask : t_gate
  task automatic t_lock();
    uvlo = 1'b1;
    cyc(8);
    chk("lock_a", 8'h00, so[0]);
    bus_wr(AD_B, 8'h04);
    chk("lock_ack", 8'h03, 8'(ak));
    chk("lock_b", 8'h00, so[1]);
    uvlo = 1'b0;
    cyc(8);
    bus_wr(AD_A, 8'h04);
    cyc(2);
    chk("unlock", 8'h90, so[0]);
  endtask : t_lock
  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", checks, bad_count);
    if (bad_count == 0 && checks > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : report_and_stop
  initial begin
    cyc(8);
    chk("rst", 8'h00, so[0] | so[1]);
    rst_n = 1'b1;
    cyc(6);
    t_write_a();
    t_read();
    t_thermal();
    t_sec_b();
    t_gate();
    t_lock();
    report_and_stop();
  end
  initial begin
    repeat (100000) @(posedge clock);
    bad_count++;
    report_and_stop();
  end
endmodule : dlp_ctrl_bench
`default_nettype wire
